//--- logic/dtc_timer.v
// Dual 16-bit timer/counter on the special function register bus
//
// Function
// [R1] Timer mode advances once per twelve clocks
// [R2] Counter mode counts falling edges, two-cycle detection
// [R3] Count input stable at least one machine cycle
// [R4] Mode register: unit one high, zero low
// [R5] Select bit chooses edge counting or cycles
// [R6] Count needs run and open gate; while split, unit one ignores its run bit and the high byte ignores the gate
// [R7] Mode 00: 13-bit count, low five bits
// [R8] Rollover to zero sets overflow flag
// [R9] Setting run does not clear counts
// [R10] Mode 01: full 16-bit count
// [R11] Mode 10: low byte reloads from high
// [R12] Unit one in mode 11 holds count
// [R13] Unit zero mode 11 splits two bytes
// [R14] Split: unit one runs without interrupt
// [R15] Flags cleared by software or acknowledge
// [R16] Control bits 7..4: flags and runs
// [R17] Control low nibble: external interrupt bits
// [R18] Reset clears mode and control registers
// [R19] Count bytes readable and writable anytime
`timescale 1ns/10ps
`include "dtc_regs.vh"
module dtc_timer (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Special function register bus
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd,
   output reg [7:0] sfr_rdata_q,
   // External pins
   input wire unit_zero_ext_input,
   input wire unit_one_ext_input,
   input wire unit_zero_gate_pin,
   input wire unit_one_gate_pin,
   // Interrupt requests and acknowledges
   input wire unit_zero_irq_ack,
   input wire unit_one_irq_ack,
   output wire unit_zero_overflow_flag,
   output wire unit_one_overflow_flag,
   // Unit one overflow strobe for the serial baud generator
   output reg unit_one_baud_tick_q
);
   reg [7:0] timer_control_q;
   reg [7:0] timer_mode_config_q;
   reg [7:0] unit_zero_low_byte_q;
   reg [7:0] unit_zero_high_byte_q;
   reg [7:0] unit_one_low_byte_q;
   reg [7:0] unit_one_high_byte_q;
   reg [3:0] mc_cnt_q;
   reg mc_tick_q;

   reg [7:0] unit_zero_low_byte_d;
   reg [7:0] unit_zero_high_byte_d;
   reg [7:0] unit_one_low_byte_d;
   reg [7:0] unit_one_high_byte_d;
   reg [7:0] timer_control_d;
   reg [7:0] rdata_d;
   reg u0_ovf;
   reg u0_high_ovf;
   reg u1_ovf;
   reg [12:0] sum13;
   reg [15:0] sum16;

   wire u0_level;
   wire u0_fall;
   wire u1_level;
   wire u1_fall;
   wire u0_gate_level;
   wire u1_gate_level;

   // Unit configuration fields [R4]
   wire [3:0] u0_cfg = timer_mode_config_q[`DTC_MOD_U0_LSB+3:`DTC_MOD_U0_LSB];
   wire [3:0] u1_cfg = timer_mode_config_q[`DTC_MOD_U1_LSB+3:`DTC_MOD_U1_LSB];
   wire [1:0] u0_mode = u0_cfg[`DTC_MOD_FIELD_HI:`DTC_MOD_FIELD_LO];
   wire [1:0] u1_mode = u1_cfg[`DTC_MOD_FIELD_HI:`DTC_MOD_FIELD_LO];
   wire u0_run = timer_control_q[`DTC_CTL_U0_RUN];
   wire u1_run = timer_control_q[`DTC_CTL_U1_RUN];
   wire split = (u0_mode == `DTC_MODE_SPLIT);

   // Count events: machine cycles or pin falling edges [R5]
   wire u0_event = u0_cfg[`DTC_MOD_CNT_SEL] ? u0_fall : mc_tick_q;
   wire u1_event = u1_cfg[`DTC_MOD_CNT_SEL] ? u1_fall : mc_tick_q;

   // Run and gate qualification [R6]
   wire u0_enable = u0_run & (~u0_cfg[`DTC_MOD_GATE] | u0_gate_level);
   // While split, unit one run bit belongs to the high byte of unit zero [R14]
   wire u1_enable = (split | u1_run) & (~u1_cfg[`DTC_MOD_GATE] | u1_gate_level);

   wire wr_ctl = sfr_wr & (sfr_addr == `DTC_ADDR_CONTROL);
   wire wr_mode = sfr_wr & (sfr_addr == `DTC_ADDR_MODE);
   wire wr_u0_low = sfr_wr & (sfr_addr == `DTC_ADDR_U0_LOW);
   wire wr_u0_high = sfr_wr & (sfr_addr == `DTC_ADDR_U0_HIGH);
   wire wr_u1_low = sfr_wr & (sfr_addr == `DTC_ADDR_U1_LOW);
   wire wr_u1_high = sfr_wr & (sfr_addr == `DTC_ADDR_U1_HIGH);

   // Pins pass two flip-flops before any logic reads them [R3]
   dtc_pin_sampler u_u0_count (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin(unit_zero_ext_input),
      .mc_tick(mc_tick_q),
      .level(u0_level),
      .fall(u0_fall)
   );

   dtc_pin_sampler u_u1_count (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin(unit_one_ext_input),
      .mc_tick(mc_tick_q),
      .level(u1_level),
      .fall(u1_fall)
   );

   dtc_pin_sampler u_u0_gate (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin(unit_zero_gate_pin),
      .mc_tick(mc_tick_q),
      .level(u0_gate_level),
      .fall()
   );

   dtc_pin_sampler u_u1_gate (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .pin(unit_one_gate_pin),
      .mc_tick(mc_tick_q),
      .level(u1_gate_level),
      .fall()
   );

   // Count byte next values; software writes win over counting [R19]
   always @* begin
      unit_zero_low_byte_d = unit_zero_low_byte_q;
      unit_zero_high_byte_d = unit_zero_high_byte_q;
      unit_one_low_byte_d = unit_one_low_byte_q;
      unit_one_high_byte_d = unit_one_high_byte_q;
      u0_ovf = 1'b0;
      u0_high_ovf = 1'b0;
      u1_ovf = 1'b0;
      sum13 = 13'h0000;
      sum16 = 16'h0000;
      // Unit zero; counts resume from held values, nothing clears them on run [R9]
      if (u0_enable && u0_event) begin
         case (u0_mode)
            `DTC_MODE_13BIT: begin
               // Upper three low-byte bits are left as they are [R7]
               sum13 = {unit_zero_high_byte_q, unit_zero_low_byte_q[4:0]} + 13'h0001;
               unit_zero_high_byte_d = sum13[12:5];
               unit_zero_low_byte_d = {unit_zero_low_byte_q[7:5], sum13[4:0]};
               u0_ovf = &{unit_zero_high_byte_q, unit_zero_low_byte_q[4:0]}; // [R7] [R8]
            end
            `DTC_MODE_16BIT: begin
               sum16 = {unit_zero_high_byte_q, unit_zero_low_byte_q} + 16'h0001;
               unit_zero_high_byte_d = sum16[15:8];
               unit_zero_low_byte_d = sum16[7:0];
               u0_ovf = &{unit_zero_high_byte_q, unit_zero_low_byte_q}; // [R10] [R8]
            end
            `DTC_MODE_RELOAD: begin
               u0_ovf = &unit_zero_low_byte_q;
               unit_zero_low_byte_d = u0_ovf ? unit_zero_high_byte_q : unit_zero_low_byte_q + 8'h01; // [R11]
            end
            default: begin
               // Split: low byte alone under unit zero controls [R13]
               unit_zero_low_byte_d = unit_zero_low_byte_q + 8'h01;
               u0_ovf = &unit_zero_low_byte_q;
            end
         endcase
      end
      // Split high byte counts machine cycles only, gated by unit one run bit [R13]
      if (split && u1_run && mc_tick_q) begin
         unit_zero_high_byte_d = unit_zero_high_byte_q + 8'h01;
         u0_high_ovf = &unit_zero_high_byte_q;
      end
      // Unit one; its own split mode simply holds the count [R12]
      if (u1_enable && u1_event) begin
         case (u1_mode)
            `DTC_MODE_13BIT: begin
               sum13 = {unit_one_high_byte_q, unit_one_low_byte_q[4:0]} + 13'h0001;
               unit_one_high_byte_d = sum13[12:5];
               unit_one_low_byte_d = {unit_one_low_byte_q[7:5], sum13[4:0]};
               u1_ovf = &{unit_one_high_byte_q, unit_one_low_byte_q[4:0]}; // [R7] [R8]
            end
            `DTC_MODE_16BIT: begin
               sum16 = {unit_one_high_byte_q, unit_one_low_byte_q} + 16'h0001;
               unit_one_high_byte_d = sum16[15:8];
               unit_one_low_byte_d = sum16[7:0];
               u1_ovf = &{unit_one_high_byte_q, unit_one_low_byte_q}; // [R10] [R8]
            end
            `DTC_MODE_RELOAD: begin
               u1_ovf = &unit_one_low_byte_q;
               unit_one_low_byte_d = u1_ovf ? unit_one_high_byte_q : unit_one_low_byte_q + 8'h01; // [R11]
            end
            default: begin
               u1_ovf = 1'b0; // [R12]
            end
         endcase
      end
      if (wr_u0_low) begin
         unit_zero_low_byte_d = sfr_wdata; // [R19]
      end
      if (wr_u0_high) begin
         unit_zero_high_byte_d = sfr_wdata; // [R19]
      end
      if (wr_u1_low) begin
         unit_one_low_byte_d = sfr_wdata; // [R19]
      end
      if (wr_u1_high) begin
         unit_one_high_byte_d = sfr_wdata; // [R19]
      end
   end

   // Control register; a hardware set wins over a software or acknowledge clear [R15]
   always @* begin
      timer_control_d = wr_ctl ? sfr_wdata : timer_control_q; // [R16] [R17]
      if (unit_zero_irq_ack && !wr_ctl) begin
         timer_control_d[`DTC_CTL_U0_OVF] = 1'b0; // [R15]
      end
      if (unit_one_irq_ack && !wr_ctl) begin
         timer_control_d[`DTC_CTL_U1_OVF] = 1'b0; // [R15]
      end
      if (u0_ovf) begin
         timer_control_d[`DTC_CTL_U0_OVF] = 1'b1; // [R8]
      end
      // Split mode hands unit one's flag to the high byte of unit zero [R13] [R14]
      if (split ? u0_high_ovf : u1_ovf) begin
         timer_control_d[`DTC_CTL_U1_OVF] = 1'b1; // [R8]
      end
   end

   // Read multiplexer; unmapped offsets read zero
   always @* begin
      case (sfr_addr)
         `DTC_ADDR_CONTROL: rdata_d = timer_control_q;
         `DTC_ADDR_MODE: rdata_d = timer_mode_config_q;
         `DTC_ADDR_U0_LOW: rdata_d = unit_zero_low_byte_q;
         `DTC_ADDR_U1_LOW: rdata_d = unit_one_low_byte_q;
         `DTC_ADDR_U0_HIGH: rdata_d = unit_zero_high_byte_q;
         `DTC_ADDR_U1_HIGH: rdata_d = unit_one_high_byte_q;
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mc_cnt_q <= 4'h0;
         mc_tick_q <= 1'b0;
         timer_control_q <= `DTC_RST_CONTROL; // [R18]
         timer_mode_config_q <= `DTC_RST_MODE; // [R18]
         unit_zero_low_byte_q <= `DTC_RST_COUNT;
         unit_zero_high_byte_q <= `DTC_RST_COUNT;
         unit_one_low_byte_q <= `DTC_RST_COUNT;
         unit_one_high_byte_q <= `DTC_RST_COUNT;
         sfr_rdata_q <= 8'h00;
         unit_one_baud_tick_q <= 1'b0;
      end else begin
         // Machine cycle strobe, one clock in every twelve [R1]
         mc_cnt_q <= (mc_cnt_q == `DTC_MC_LAST) ? 4'h0 : mc_cnt_q + 4'h1;
         mc_tick_q <= (mc_cnt_q == `DTC_MC_LAST);
         timer_control_q <= timer_control_d;
         if (wr_mode) begin
            timer_mode_config_q <= sfr_wdata; // [R4]
         end
         unit_zero_low_byte_q <= unit_zero_low_byte_d;
         unit_zero_high_byte_q <= unit_zero_high_byte_d;
         unit_one_low_byte_q <= unit_one_low_byte_d;
         unit_one_high_byte_q <= unit_one_high_byte_d;
         if (sfr_rd) begin
            sfr_rdata_q <= rdata_d;
         end
         // Baud source keeps working even while split steals the flag [R14]
         unit_one_baud_tick_q <= u1_ovf;
      end
   end

   // Flags come straight from the control register flip-flops
   assign unit_zero_overflow_flag = timer_control_q[`DTC_CTL_U0_OVF];
   assign unit_one_overflow_flag = timer_control_q[`DTC_CTL_U1_OVF];
endmodule // dtc_timer

//--- logic/dtc_regs.vh
// Register offsets, field positions, reset values and timing counts of the dual timer/counter
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

// Register offsets on the special function register bus
`define DTC_ADDR_CONTROL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_U0_LOW 8'h8A
`define DTC_ADDR_U1_LOW 8'h8B
`define DTC_ADDR_U0_HIGH 8'h8C
`define DTC_ADDR_U1_HIGH 8'h8D

// Reset values
`define DTC_RST_CONTROL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_COUNT 8'h00

// Control register fields
`define DTC_CTL_U1_OVF 7
`define DTC_CTL_U1_RUN 6
`define DTC_CTL_U0_OVF 5
`define DTC_CTL_U0_RUN 4
`define DTC_CTL_IRQ1_EDGE 3
`define DTC_CTL_IRQ1_TYPE 2
`define DTC_CTL_IRQ0_EDGE 1
`define DTC_CTL_IRQ0_TYPE 0

// Mode register fields, within each unit's nibble
`define DTC_MOD_U1_LSB 4
`define DTC_MOD_U0_LSB 0
`define DTC_MOD_GATE 3
`define DTC_MOD_CNT_SEL 2
`define DTC_MOD_FIELD_HI 1
`define DTC_MOD_FIELD_LO 0

// Mode field encodings
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// One machine cycle in processor clocks
`define DTC_MC_CLKS 12
`define DTC_MC_LAST 4'hB

`endif

//--- logic/dtc_pin_sampler.v
// Synchroniser and machine-cycle falling-edge detector for one external pin
`timescale 1ns/10ps
module dtc_pin_sampler (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Pin and machine-cycle strobe
   input wire pin,
   input wire mc_tick,
   // Sampled results
   output wire level,
   output wire fall
);
   reg sync1_q;
   reg sync2_q;
   reg samp_q;
   reg prev_q;

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
         samp_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         sync1_q <= pin;
         sync2_q <= sync1_q;
         // Sampling once per machine cycle; a level shorter than that may be missed
         if (mc_tick) begin
            samp_q <= sync2_q;
            prev_q <= samp_q;
         end
      end
   end

   assign level = sync2_q;
   // High sample followed by low sample: the edge shows two machine cycles after it happens [R2]
   assign fall = mc_tick & prev_q & ~samp_q;
endmodule // dtc_pin_sampler

//--- testbench/dtc_pin_model.sv
// Behavioural source for an external count pin
`timescale 1ns/10ps
module dtc_pin_model (
   // Clock and start request
   input wire clk_sys,
   input wire go,
   // Number of falling edges to make
   input wire [7:0] n_falls,
   // Driven pin
   output reg pin
);
   integer k;
   initial pin = 1'b1;
   // Each level held 13 clocks, just over one machine cycle, the tightest legal source
   always @(posedge go) begin
      for (k = 0; k < n_falls; k = k + 1) begin
         repeat (13) @(negedge clk_sys);
         pin = 1'b0;
         repeat (13) @(negedge clk_sys);
         pin = 1'b1;
      end
   end
endmodule // dtc_pin_model

//--- testbench/dtc_timer_assertions.sv
// Port-level assertions for the dual timer/counter
`timescale 1ns/10ps
module dtc_timer_assertions (
   // Clock and reset
   input wire clk_sys,
   input wire rst_b,
   // Register bus
   input wire [7:0] sfr_addr,
   input wire sfr_wr,
   input wire [7:0] sfr_wdata,
   input wire sfr_rd,
   input wire [7:0] sfr_rdata_q,
   // Interrupt side
   input wire unit_zero_irq_ack,
   input wire unit_one_irq_ack,
   input wire unit_zero_overflow_flag,
   input wire unit_one_overflow_flag,
   input wire unit_one_baud_tick_q
);
   // Shadow of the machine-cycle divider; its strobe is registered like the design's,
   // so a count lands one clock after the divider wraps, not on its last state
   reg [3:0] mc_q;
   reg tick_q;
   wire tick = tick_q;
   wire wr_ctl = sfr_wr && (sfr_addr == 8'h88);
   wire set0 = wr_ctl && sfr_wdata[5];
   wire set1 = wr_ctl && sfr_wdata[7];
   wire [1:0] wr_f = {sfr_wdata[7], sfr_wdata[5]};
   wire [1:0] flg = {unit_one_overflow_flag, unit_zero_overflow_flag};
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         mc_q <= 4'h0;
         tick_q <= 1'b0;
      end else begin
         mc_q <= (mc_q == 4'hB) ? 4'h0 : mc_q + 4'h1;
         tick_q <= (mc_q == 4'hB);
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_rst; $rose(rst_b) |-> flg == 2'b00 && sfr_rdata_q == 8'h00; endproperty
   a_rst: assert property (p_rst) else $error("state not clear after reset");
   property p_f0_set; $rose(unit_zero_overflow_flag) |-> $past(tick) || $past(set0); endproperty
   a_f0_set: assert property (p_f0_set) else $error("unit zero flag set off a tick");
   property p_f1_set; $rose(unit_one_overflow_flag) |-> $past(tick) || $past(set1); endproperty
   a_f1_set: assert property (p_f1_set) else $error("unit one flag set off a tick");
   property p_ack0; unit_zero_irq_ack && !wr_ctl && !tick |=> !unit_zero_overflow_flag; endproperty
   a_ack0: assert property (p_ack0) else $error("ack left unit zero flag set");
   property p_ack1; unit_one_irq_ack && !wr_ctl && !tick |=> !unit_one_overflow_flag; endproperty
   a_ack1: assert property (p_ack1) else $error("ack left unit one flag set");
   property p_ctl_wr; wr_ctl && !tick |=> flg == $past(wr_f); endproperty
   a_ctl_wr: assert property (p_ctl_wr) else $error("control write missed the flags");
   property p_rd_ctl; sfr_rd && sfr_addr == 8'h88 |=> {sfr_rdata_q[7], sfr_rdata_q[5]} == $past(flg); endproperty
   a_rd_ctl: assert property (p_rd_ctl) else $error("control read shows wrong flags");
   property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata_q); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");
   property p_baud; unit_one_baud_tick_q |-> $past(tick) ##1 !unit_one_baud_tick_q; endproperty
   a_baud: assert property (p_baud) else $error("baud strobe off a tick or too long");
endmodule // dtc_timer_assertions
bind dtc_timer dtc_timer_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(sfr_rdata_q),
   .unit_zero_irq_ack(unit_zero_irq_ack), .unit_one_irq_ack(unit_one_irq_ack),
   .unit_zero_overflow_flag(unit_zero_overflow_flag), .unit_one_overflow_flag(unit_one_overflow_flag),
   .unit_one_baud_tick_q(unit_one_baud_tick_q));

//--- testbench/dtc_timer_tb.sv
// Self-checking bench for the dual timer/counter
`timescale 1ns/10ps
`define CHK(nm, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
   n_errors = n_errors + 1; $display("Error %s expected %h seen %h", nm, e, g); end end
module dtc_timer_tb;
   reg clk_sys = 1'b0;
   reg rst_b = 1'b0;
   reg [7:0] sfr_addr = 8'h00;
   reg sfr_wr = 1'b0;
   reg [7:0] sfr_wdata = 8'h00;
   reg sfr_rd = 1'b0;
   reg gate0 = 1'b0;
   reg gate1 = 1'b0;
   reg ack0 = 1'b0;
   reg ack1 = 1'b0;
   reg go = 1'b0;
   wire [7:0] rdata;
   wire pin0, flag0, flag1;
   integer n_errors = 0;
   integer total_checks = 0;
   always #50 clk_sys = ~clk_sys;
   dtc_pin_model PIN (.clk_sys(clk_sys), .go(go), .n_falls(8'h03), .pin(pin0));
   dtc_timer DUT (.clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata_q(rdata), .unit_zero_ext_input(pin0),
      .unit_one_ext_input(pin0), .unit_zero_gate_pin(gate0), .unit_one_gate_pin(gate1),
      .unit_zero_irq_ack(ack0), .unit_one_irq_ack(ack1), .unit_zero_overflow_flag(flag0),
      .unit_one_overflow_flag(flag1), .unit_one_baud_tick_q());
   // Idle cycle after each access keeps a strobe from being set twice in one step
   task wr(input [7:0] a, input [7:0] d); begin
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys) sfr_wr = 1'b0;
      @(negedge clk_sys);
   end endtask
   task rd(input [7:0] a, output [7:0] v); begin
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys) sfr_rd = 1'b0;
      v = rdata;
      @(negedge clk_sys);
   end endtask
   // Run for exactly 120 edges, ten machine cycles; flags sampled and acked before the stop
   task win(input [7:0] c, output [1:0] f); begin
      wr(8'h88, c);
      repeat (117) @(negedge clk_sys);
      f = {flag1, flag0};
      ack0 = 1'b1;
      ack1 = 1'b1;
      @(negedge clk_sys);
      ack0 = 1'b0;
      ack1 = 1'b0;
      // Looked at before the stop write, which would clear the flags by itself
      `CHK("flags cleared by ack", 2'b00, {flag1, flag0})
      wr(8'h88, 8'h00);
   end endtask
   task run_case(input u, input [7:0] md, c, lo, hi, elo, ehi, input [1:0] ef);
      reg [7:0] v;
      reg [1:0] f;
      begin
         wr(8'h89, md);
         wr(8'h8A + u, lo);
         wr(8'h8C + u, hi);
         win(c, f);
         rd(8'h8A + u, v);
         `CHK("low byte", elo, v)
         rd(8'h8C + u, v);
         `CHK("high byte", ehi, v)
         `CHK("overflow flags", ef, f)
         `CHK("flags after ack", 2'b00, {flag1, flag0})
      end
   endtask
   task t_regs;
      reg [7:0] v;
      begin
         rd(8'h88, v);
         `CHK("control reset", 8'h00, v)
         rd(8'h89, v);
         `CHK("mode reset", 8'h00, v)
         wr(8'h89, 8'hA5);
         rd(8'h89, v);
         `CHK("mode readback", 8'hA5, v)
         wr(8'h88, 8'h0F);
         rd(8'h88, v);
         `CHK("control low nibble", 8'h0F, v)
         wr(8'h88, 8'h00);
         wr(8'h90, 8'hFF);
         rd(8'h90, v);
         `CHK("unmapped read", 8'h00, v)
      end
   endtask
   // 200 edges would be 16 machine cycles, so a timer-mode count cannot pass
   task t_count;
      reg [7:0] v;
      begin
         wr(8'h89, 8'h55);
         wr(8'h8A, 8'h00);
         wr(8'h8C, 8'h00);
         wr(8'h8B, 8'h00);
         wr(8'h8D, 8'h00);
         wr(8'h88, 8'h50);
         go = 1'b1;
         repeat (200) @(negedge clk_sys);
         wr(8'h88, 8'h00);
         rd(8'h8A, v);
         `CHK("edge count", 8'h03, v)
         rd(8'h8B, v);
         `CHK("unit one edge count", 8'h03, v)
         go = 1'b0;
      end
   endtask
   task stop_test; begin
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end endtask
   initial begin
      repeat (6000) @(posedge clk_sys);
      n_errors = n_errors + 1;
      stop_test;
   end
   initial begin
      repeat (16) @(negedge clk_sys);
      rst_b = 1'b1;
      @(negedge clk_sys);
      t_regs;
      run_case(1'b0, 8'h01, 8'h10, 8'hFE, 8'hFF, 8'h08, 8'h00, 2'b01);
      run_case(1'b0, 8'h00, 8'h10, 8'hFE, 8'hFF, 8'hE8, 8'h00, 2'b01);
      run_case(1'b0, 8'h02, 8'h10, 8'hFE, 8'hF0, 8'hF8, 8'hF0, 2'b01);
      run_case(1'b1, 8'h10, 8'h40, 8'hFE, 8'hFF, 8'h08, 8'h00, 2'b10);
      run_case(1'b1, 8'h30, 8'h40, 8'h12, 8'h34, 8'h12, 8'h34, 2'b00);
      run_case(1'b0, 8'h03, 8'h50, 8'hFE, 8'hFE, 8'h08, 8'h08, 2'b11);
      run_case(1'b0, 8'h09, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 2'b00);
      gate0 = 1'b1;
      run_case(1'b0, 8'h09, 8'h10, 8'h00, 8'h00, 8'h0A, 8'h00, 2'b00);
      run_case(1'b1, 8'h90, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 2'b00);
      gate1 = 1'b1;
      run_case(1'b1, 8'h90, 8'h40, 8'h00, 8'h00, 8'h0A, 8'h00, 2'b00);
      t_count;
      stop_test;
   end
endmodule // dtc_timer_tb
